// ===== src/clock_synth_smbus_config.sv
// Serial configuration port and output-mode control of the clock synthesizer
//
// Overview of operation
// - Answer only address byte D2h, write direction.
// - Only block writes accepted; no indexed access.
// - Byte count equals number of following data bytes.
// - Bytes ascend from zero, MSB first, stoppable.
// - Transfer valid once count acknowledge is clocked.
// - Configuration bytes take defaults at power-up.
// - Byte zero bit 7 enables down-spread.
// - Byte zero bit 5 picks 66/48 MHz.
// - Byte zero bit 4 mirrors CPU stop pin.
// - Byte zero bit 3 stops gated PCI only.
// - Byte zero bits 2..0 show latched straps.
// - Test mode clocks everything from test clock.
// - Test mode uses the TEST_*_DIV dividers; other modes use NO_DIV.
// - Mid/00 tristates outputs; mid/01 is test mode; mid/10 and mid/11 reserved.
// - Straps sampled once on power-good strobe low.
// - Power-down and stop pins are active low.
`timescale 1ns/1ps
module clock_synth_smbus_config (
  // Clock and reset
  input  wire logic                         clock,
  input  wire logic                         rst,
  // Serial port pins, open drain data
  input  wire clock_synth_pkg::smbus_in_t   busIn,
  output logic                              sdaOut,
  output logic                              sdaOe,
  // Strap pins and power-good strobe
  input  wire clock_synth_pkg::strap_t      strapIn,
  input  wire logic                         power_good_strobe_n,
  // Power management pins
  input  wire logic                         power_down_n,
  input  wire logic                         pciStopN,
  input  wire logic                         cpuStopN,
  // Status and output control
  output logic [7:0]                        controlByte,
  output clock_synth_pkg::strap_t           strapLatched,
  output logic                              strapsTaken,
  output logic                              transferValid,
  output clock_synth_pkg::clock_ctrl_t      clockCtrl
);
  import clock_synth_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ADDR   = 3'b001,
    ST_CMD    = 3'b011,
    ST_COUNT  = 3'b010,
    ST_DATA   = 3'b110,
    ST_IGNORE = 3'b111
  } link_state_t;

  link_state_t        state;
  logic               startSeen;
  logic               stopSeen;
  logic               byteValid;
  logic [7:0]         byteData;
  logic               ackClocked;
  logic               ackGo;
  logic               accept;
  logic               countAckPending;
  logic [7:0]         byteCount;
  logic [INDEX_W-1:0] dataIndex;
  logic [7:0]         writable;
  strap_t             strapSync0;
  strap_t             strapSync1;
  logic [1:0]         pgoodSync;
  logic [1:0]         pdSync;
  logic [1:0]         pciSync;
  logic [1:0]         cpuSync;
  logic               powerDown;
  logic               pciStopped;
  logic               cpuStopped;
  out_mode_t          next_mode;

  ////////////////////////////////////////////////////////////////////////////////
  // Bit-level receiver
  smbus_byte_receiver receiver (
    .clock      (clock),
    .rst        (rst),
    .busIn      (busIn),
    .sdaOe      (sdaOe),
    .ackGo      (ackGo),
    .startSeen  (startSeen),
    .stopSeen   (stopSeen),
    .byteValid  (byteValid),
    .byteData   (byteData),
    .ackClocked (ackClocked)
  );

  // Open drain: only ever pulls low
  always_ff @(posedge clock) begin
    sdaOut <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Byte acceptance decision
  always_comb begin
    case (state)
      ST_ADDR:  accept = (byteData == SLAVE_ADDR_BYTE);
      ST_CMD:   accept = (byteData == COMMAND_CODE);
      ST_COUNT: accept = (byteData >= COUNT_MIN) && (byteData <= COUNT_MAX);
      ST_DATA:  accept = 1'b1;
      default:  accept = 1'b0;
    endcase
  end

  // Decided long before the falling clock of the eighth bit
  always_ff @(posedge clock) begin
    if (rst || startSeen) begin
      ackGo <= 1'b0;
    end else if (byteValid) begin
      ackGo <= accept;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transfer state machine
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= ST_IDLE;
    end else if (startSeen) begin
      state <= ST_ADDR;
    end else if (stopSeen) begin
      state <= ST_IDLE;
    end else if (byteValid) begin
      case (state)
        ST_ADDR:  state <= accept ? ST_CMD : ST_IGNORE;
        ST_CMD:   state <= accept ? ST_COUNT : ST_IGNORE;
        ST_COUNT: state <= accept ? ST_DATA : ST_IGNORE;
        ST_DATA:  begin
          // Bytes beyond the announced count are refused
          if (8'(dataIndex) + 8'h01 >= byteCount) begin
            state <= ST_IGNORE;
          end
        end
        ST_IDLE:   state <= ST_IDLE;
        ST_IGNORE: state <= ST_IGNORE;
        default:   state <= ST_IDLE;
      endcase
    end
  end

  // Count and data index
  always_ff @(posedge clock) begin
    if (rst) begin
      byteCount <= 8'h00;
      dataIndex <= '0;
    end else if (byteValid && state == ST_COUNT && accept) begin
      byteCount <= byteData;
      dataIndex <= '0;
    end else if (byteValid && state == ST_DATA) begin
      dataIndex <= dataIndex + INDEX_W'(1);
    end
  end

  // Validity only after the controller has clocked the count acknowledge
  always_ff @(posedge clock) begin
    if (rst || startSeen) begin
      countAckPending <= 1'b0;
      transferValid   <= 1'b0;
    end else if (byteValid && state == ST_COUNT && accept) begin
      countAckPending <= 1'b1;
    end else if (ackClocked && countAckPending) begin
      countAckPending <= 1'b0;
      transferValid   <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Writable bits of control byte zero; later bytes are taken but discarded
  always_ff @(posedge clock) begin
    if (rst) begin
      writable <= CONTROL_RESET;
    end else if (byteValid && state == ST_DATA && transferValid && dataIndex == '0) begin
      writable <= byteData & WRITE_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers for straps and power pins
  always_ff @(posedge clock) begin
    if (rst) begin
      strapSync0 <= '0;
      strapSync1 <= '0;
      pgoodSync  <= 2'h3;
      pdSync     <= 2'h0;
      pciSync    <= 2'h3;
      cpuSync    <= 2'h3;
    end else begin
      strapSync0 <= strapIn;
      strapSync1 <= strapSync0;
      pgoodSync  <= {pgoodSync[0], power_good_strobe_n};
      pdSync     <= {pdSync[0], power_down_n};
      pciSync    <= {pciSync[0], pciStopN};
      cpuSync    <= {cpuSync[0], cpuStopN};
    end
  end

  assign powerDown  = !pdSync[1];
  assign pciStopped = !pciSync[1];
  assign cpuStopped = !cpuSync[1];

  // One-shot strap capture; the strobe is ignored afterwards
  always_ff @(posedge clock) begin
    if (rst) begin
      strapLatched <= '0;
      strapsTaken  <= 1'b0;
    end else if (!strapsTaken && !pgoodSync[1]) begin
      strapLatched <= strapSync1;
      strapsTaken  <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control byte image
  always_ff @(posedge clock) begin
    if (rst) begin
      controlByte <= CONTROL_RESET;
    end else begin
      controlByte                 <= writable;
      controlByte[CPU_STOP_BIT]   <= cpuSync[1];
      controlByte[MODE_BIT]       <= (strapLatched.modeSelectTriLevel == TRI_HIGH);
      controlByte[FREQ_HI_BIT]    <= strapLatched.cpuFreqSelectHi;
      controlByte[FREQ_LO_BIT]    <= strapLatched.cpuFreqSelectLo;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output mode decode
  always_comb begin
    case (strapLatched.modeSelectTriLevel)
      TRI_HIGH: next_mode = OUT_BUFFERED;
      TRI_LOW:  next_mode = OUT_INTERNAL;
      TRI_MID:  begin
        case ({strapLatched.cpuFreqSelectHi, strapLatched.cpuFreqSelectLo})
          2'b00:   next_mode = OUT_HIZ;
          2'b01:   next_mode = OUT_TEST;
          default: next_mode = OUT_RESERVED;
        endcase
      end
      default:  next_mode = OUT_RESERVED;
    endcase
  end

  // Source, dividers and frequency
  always_ff @(posedge clock) begin
    if (rst) begin
      clockCtrl.mode            <= OUT_INTERNAL;
      clockCtrl.cpuFreq         <= CPU_66;
      clockCtrl.testClockSource <= 1'b0;
      clockCtrl.outputsHiZ      <= 1'b0;
      clockCtrl.spreadOn        <= 1'b0;
      clockCtrl.sharedSelect48  <= 1'b0;
      clockCtrl.cpuDiv          <= NO_DIV;
      clockCtrl.sixtySixDiv     <= NO_DIV;
      clockCtrl.pciDiv          <= NO_DIV;
      clockCtrl.refDiv          <= NO_DIV;
      clockCtrl.dot48Div        <= NO_DIV;
    end else begin
      clockCtrl.mode            <= next_mode;
      clockCtrl.cpuFreq         <= cpu_freq_t'({strapLatched.cpuFreqSelectHi,
                                                strapLatched.cpuFreqSelectLo});
      clockCtrl.testClockSource <= (next_mode == OUT_TEST);
      clockCtrl.outputsHiZ      <= (next_mode == OUT_HIZ);
      clockCtrl.spreadOn        <= writable[SPREAD_BIT];
      clockCtrl.sharedSelect48  <= writable[SHARED_SEL_BIT];
      if (next_mode == OUT_TEST) begin
        clockCtrl.cpuDiv      <= TEST_CPU_DIV;
        clockCtrl.sixtySixDiv <= TEST_66_DIV;
        clockCtrl.pciDiv      <= TEST_PCI_DIV;
        clockCtrl.refDiv      <= TEST_REF_DIV;
        clockCtrl.dot48Div    <= TEST_48_DIV;
      end else begin
        clockCtrl.cpuDiv      <= NO_DIV;
        clockCtrl.sixtySixDiv <= NO_DIV;
        clockCtrl.pciDiv      <= NO_DIV;
        clockCtrl.refDiv      <= NO_DIV;
        clockCtrl.dot48Div    <= NO_DIV;
      end
    end
  end

  // Gating; outputs stay parked until the straps are known
  always_ff @(posedge clock) begin
    if (rst) begin
      clockCtrl.oscRun       <= 1'b1;
      clockCtrl.cpuOn        <= 1'b0;
      clockCtrl.cpuCompOn    <= 1'b0;
      clockCtrl.cpuCompFloat <= 1'b0;
      clockCtrl.sixtySixOn   <= 1'b0;
      clockCtrl.bufferedOn   <= 1'b0;
      clockCtrl.pciFreeOn    <= 1'b0;
      clockCtrl.pciGatedOn   <= 1'b0;
      clockCtrl.usbDotOn     <= 1'b0;
      clockCtrl.refOn        <= 1'b0;
    end else if (powerDown) begin
      clockCtrl.oscRun       <= 1'b0;
      clockCtrl.cpuOn        <= 1'b0;
      clockCtrl.cpuCompOn    <= 1'b0;
      clockCtrl.cpuCompFloat <= 1'b1;
      clockCtrl.sixtySixOn   <= 1'b0;
      clockCtrl.bufferedOn   <= 1'b0;
      clockCtrl.pciFreeOn    <= 1'b0;
      clockCtrl.pciGatedOn   <= 1'b0;
      clockCtrl.usbDotOn     <= 1'b0;
      clockCtrl.refOn        <= 1'b0;
    end else begin
      clockCtrl.oscRun       <= 1'b1;
      clockCtrl.cpuOn        <= strapsTaken;
      clockCtrl.cpuCompOn    <= strapsTaken && !cpuStopped;
      clockCtrl.cpuCompFloat <= cpuStopped && pciStopped;
      clockCtrl.sixtySixOn   <= strapsTaken;
      clockCtrl.bufferedOn   <= strapsTaken;
      clockCtrl.pciFreeOn    <= strapsTaken;
      clockCtrl.pciGatedOn   <= strapsTaken && !pciStopped && !writable[PCI_STOP_BIT];
      clockCtrl.usbDotOn     <= strapsTaken;
      clockCtrl.refOn        <= strapsTaken;
    end
  end

endmodule

// ===== src/clock_synth_pkg.sv
// Shared constants and types for the clock synthesizer configuration block
package clock_synth_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Serial port framing
  localparam logic [7:0] SLAVE_ADDR_BYTE = 8'hd2;
  localparam logic [7:0] COMMAND_CODE    = 8'h00;
  localparam logic [7:0] COUNT_MIN       = 8'h01;
  localparam logic [7:0] COUNT_MAX       = 8'h20;
  localparam int         INDEX_W         = 6;
  localparam logic [3:0] LAST_BIT_COUNT  = 4'h7;
  localparam logic [3:0] BYTE_BITS       = 4'h8;

  ////////////////////////////////////////////////////////////////////////////////
  // Control byte zero layout
  localparam int         SPREAD_BIT     = 7;
  localparam int         SHARED_SEL_BIT = 5;
  localparam int         CPU_STOP_BIT   = 4;
  localparam int         PCI_STOP_BIT   = 3;
  localparam int         MODE_BIT       = 2;
  localparam int         FREQ_HI_BIT    = 1;
  localparam int         FREQ_LO_BIT    = 0;
  localparam logic [7:0] CONTROL_RESET  = 8'h00;
  localparam logic [7:0] WRITE_MASK     = 8'ha8;

  ////////////////////////////////////////////////////////////////////////////////
  // Test-clock dividers, loaded in test mode only; every other mode gets NO_DIV
  localparam int         DIV_W          = 4;
  localparam logic [3:0] TEST_CPU_DIV   = 4'h2;
  localparam logic [3:0] TEST_66_DIV    = 4'h4;
  localparam logic [3:0] TEST_PCI_DIV   = 4'h8;
  localparam logic [3:0] TEST_REF_DIV   = 4'h1;
  localparam logic [3:0] TEST_48_DIV    = 4'h2;
  localparam logic [3:0] NO_DIV         = 4'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    TRI_LOW  = 2'b00,
    TRI_MID  = 2'b01,
    TRI_HIGH = 2'b10
  } tri_level_t;

  typedef enum logic [1:0] {
    CPU_66  = 2'b00,
    CPU_100 = 2'b01,
    CPU_200 = 2'b10,
    CPU_133 = 2'b11
  } cpu_freq_t;

  typedef enum logic [2:0] {
    OUT_INTERNAL = 3'b000,
    OUT_BUFFERED = 3'b001,
    OUT_TEST     = 3'b011,
    OUT_HIZ      = 3'b010,
    OUT_RESERVED = 3'b110
  } out_mode_t;

  typedef struct packed {
    tri_level_t modeSelectTriLevel;
    logic       cpuFreqSelectHi;
    logic       cpuFreqSelectLo;
    logic       currentMultiplierSelect;
  } strap_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } smbus_in_t;

  typedef struct packed {
    out_mode_t        mode;
    cpu_freq_t        cpuFreq;
    logic             oscRun;
    logic             testClockSource;
    logic             outputsHiZ;
    logic             spreadOn;
    logic             sharedSelect48;
    logic [DIV_W-1:0] cpuDiv;
    logic [DIV_W-1:0] sixtySixDiv;
    logic [DIV_W-1:0] pciDiv;
    logic [DIV_W-1:0] refDiv;
    logic [DIV_W-1:0] dot48Div;
    logic             cpuOn;
    logic             cpuCompOn;
    logic             cpuCompFloat;
    logic             sixtySixOn;
    logic             bufferedOn;
    logic             pciFreeOn;
    logic             pciGatedOn;
    logic             usbDotOn;
    logic             refOn;
  } clock_ctrl_t;

endpackage

// ===== src/smbus_byte_receiver.sv
// Bit-level serial receiver: start/stop detection, byte shift and acknowledge drive
`timescale 1ns/1ps
module smbus_byte_receiver (
  // Clock and reset
  input  wire logic                       clock,
  input  wire logic                       rst,
  // Bus pins
  input  wire clock_synth_pkg::smbus_in_t busIn,
  output logic                            sdaOe,
  // Byte handshake
  input  wire logic                       ackGo,
  output logic                            startSeen,
  output logic                            stopSeen,
  output logic                            byteValid,
  output logic [7:0]                      byteData,
  output logic                            ackClocked
);
  import clock_synth_pkg::*;

  logic [1:0] sclSync;
  logic [1:0] sdaSync;
  logic       sclPrev;
  logic       sdaPrev;
  logic [3:0] bitCount;
  logic       inAck;
  logic       sclRise;
  logic       sclFall;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only the second stage is looked at
  always_ff @(posedge clock) begin
    if (rst) begin
      sclSync <= 2'h3;
      sdaSync <= 2'h3;
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclSync <= {sclSync[0], busIn.scl};
      sdaSync <= {sdaSync[0], busIn.sda};
      sclPrev <= sclSync[1];
      sdaPrev <= sdaSync[1];
    end
  end

  assign sclRise = sclSync[1] && !sclPrev;
  assign sclFall = !sclSync[1] && sclPrev;

  ////////////////////////////////////////////////////////////////////////////////
  // Framing events
  always_ff @(posedge clock) begin
    if (rst) begin
      startSeen <= 1'b0;
      stopSeen  <= 1'b0;
    end else begin
      startSeen <= sclSync[1] && sclPrev && sdaPrev && !sdaSync[1];
      stopSeen  <= sclSync[1] && sclPrev && !sdaPrev && sdaSync[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bit counter, shifter and acknowledge slot
  always_ff @(posedge clock) begin
    if (rst) begin
      bitCount   <= 4'h0;
      inAck      <= 1'b0;
      sdaOe      <= 1'b0;
      byteData   <= 8'h00;
      byteValid  <= 1'b0;
      ackClocked <= 1'b0;
    end else begin
      byteValid  <= 1'b0;
      ackClocked <= 1'b0;
      if (sclSync[1] && sclPrev && (sdaPrev != sdaSync[1])) begin
        // Start or stop: resynchronise the byte frame and let go of the line
        bitCount <= 4'h0;
        inAck    <= 1'b0;
        sdaOe    <= 1'b0;
      end else if (sclRise) begin
        if (inAck) begin
          ackClocked <= sdaOe;
        end else if (bitCount < BYTE_BITS) begin
          byteData <= {byteData[6:0], sdaSync[1]};
          bitCount <= bitCount + 4'h1;
          byteValid <= (bitCount == LAST_BIT_COUNT);
        end
      end else if (sclFall) begin
        if (!inAck && bitCount == BYTE_BITS) begin
          inAck    <= 1'b1;
          bitCount <= 4'h0;
          sdaOe    <= ackGo;
        end else if (inAck) begin
          inAck <= 1'b0;
          sdaOe <= 1'b0;
        end
      end
    end
  end

endmodule

// ===== tb/clock_synth_smbus_config_props.sv
// Concurrent checks on the ports of the configuration block
`timescale 1ns/1ps
module clock_synth_smbus_config_props (
  // Clock and reset
  input wire logic                         clock,
  input wire logic                         rst,
  // Serial pins
  input wire clock_synth_pkg::smbus_in_t   busIn,
  input wire logic                         sdaOut,
  input wire logic                         sdaOe,
  // Strap and power pins
  input wire clock_synth_pkg::strap_t      strapIn,
  input wire logic                         power_good_strobe_n,
  input wire logic                         power_down_n,
  input wire logic                         pciStopN,
  input wire logic                         cpuStopN,
  // Status and output control
  input wire logic [7:0]                   controlByte,
  input wire clock_synth_pkg::strap_t      strapLatched,
  input wire logic                         strapsTaken,
  input wire logic                         transferValid,
  input wire clock_synth_pkg::clock_ctrl_t clockCtrl
);
  import clock_synth_pkg::*;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////////
  // Three cycles of held straps, so the decoded outputs have caught up
  sequence settled;
    strapsTaken [*3];
  endsequence

  sequence inCode(tri_level_t m, logic h, logic l);
    settled ##0 (strapLatched.modeSelectTriLevel == m && strapLatched.cpuFreqSelectHi == h
      && strapLatched.cpuFreqSelectLo == l);
  endsequence

  reset_value_a: assert property (disable iff (1'b0) rst |=> controlByte == CONTROL_RESET
      && !transferValid && !sdaOe) else $error("Reset state wrong");
  strap_hold_a: assert property (strapsTaken |=> strapsTaken && $stable(strapLatched))
    else $error("Straps changed after capture");
  strap_mirror_a: assert property (settled |-> controlByte[2:0] == {strapLatched.modeSelectTriLevel == TRI_HIGH,
      strapLatched.cpuFreqSelectHi, strapLatched.cpuFreqSelectLo}) else $error("Strap bits wrong");
  hiz_mode_a: assert property (inCode(TRI_MID, 1'b0, 1'b0) |-> clockCtrl.outputsHiZ
      && clockCtrl.mode == OUT_HIZ) else $error("Hi-Z mode wrong");
  test_div_a: assert property (inCode(TRI_MID, 1'b0, 1'b1) |-> clockCtrl.testClockSource &&
      {clockCtrl.cpuDiv, clockCtrl.sixtySixDiv, clockCtrl.pciDiv, clockCtrl.refDiv, clockCtrl.dot48Div}
      == {TEST_CPU_DIV, TEST_66_DIV, TEST_PCI_DIV, TEST_REF_DIV, TEST_48_DIV}) else $error("Test dividers wrong");
  buffer_mode_a: assert property (settled ##0 strapLatched.modeSelectTriLevel == TRI_HIGH |->
      clockCtrl.mode == OUT_BUFFERED && clockCtrl.cpuFreq == {strapLatched.cpuFreqSelectHi,
      strapLatched.cpuFreqSelectLo}) else $error("Buffered mode wrong");
  internal_mode_a: assert property (settled ##0 strapLatched.modeSelectTriLevel == TRI_LOW |->
      clockCtrl.mode == OUT_INTERNAL) else $error("Internal mode wrong");
  power_off_a: assert property ((!power_down_n) [*6] |-> !clockCtrl.oscRun && !clockCtrl.refOn
      && !clockCtrl.pciFreeOn) else $error("Power-down did not stop outputs");
  pci_gate_a: assert property (controlByte[PCI_STOP_BIT] [*6] |-> !clockCtrl.pciGatedOn)
    else $error("Gated PCI not stopped");
  free_pci_a: assert property ((power_down_n && strapsTaken && clockCtrl.mode != OUT_HIZ) [*6]
      |-> clockCtrl.pciFreeOn) else $error("Free PCI stopped");
  stop_mirror_a: assert property ($stable(cpuStopN) [*6] |-> controlByte[CPU_STOP_BIT] == cpuStopN)
    else $error("CPU stop bit not following pin");
  ack_low_a: assert property ($rose(sdaOe) |-> !busIn.scl && sdaOut == 1'b0)
    else $error("Acknowledge while serial clock high");
endmodule

// ===== tb/smbus_host_model.sv
// Behavioural serial host issuing block writes
`timescale 1ns/1ps
module smbus_host_model (
  // Clock
  input  wire logic clock,
  // Bus lines, data resolved outside
  input  wire logic sdaIn,
  output logic      scl,
  output logic      sdaLow
);
  // Twice the minimum half period, for margin
  localparam int HALF = 8;

  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end

  task automatic pause();
    repeat (HALF) @(posedge clock);
  endtask

  task automatic start_cond();
    sdaLow <= 1'b1;
    pause();
    scl <= 1'b0;
    pause();
  endtask

  // Ninth bit is released so the device can acknowledge
  task automatic send_byte(input logic [7:0] b, output logic acked);
    logic [8:0] bits;
    bits = {b, 1'b1};
    for (int i = 8; i >= 0; i--) begin
      sdaLow <= !bits[i];
      pause();
      scl <= 1'b1;
      pause();
      acked = (sdaIn === 1'b0);
      scl <= 1'b0;
      pause();
    end
  endtask

  task automatic stop_cond();
    sdaLow <= 1'b1;
    pause();
    scl <= 1'b1;
    pause();
    sdaLow <= 1'b0;
    pause();
  endtask
endmodule

// ===== tb/clock_synth_smbus_config_test.sv
// Self-checking bench of the configuration block
`timescale 1ns/1ps
bind clock_synth_smbus_config clock_synth_smbus_config_props i_props (.clock, .rst, .busIn, .sdaOut, .sdaOe,
  .strapIn, .power_good_strobe_n, .power_down_n, .pciStopN, .cpuStopN, .controlByte, .strapLatched,
  .strapsTaken, .transferValid, .clockCtrl);

module clock_synth_smbus_config_test;
  import clock_synth_pkg::*;

  logic        clock, scl, sdaLow, sdaOut, sdaOe, strapsTaken, transferValid;
  logic        rst = 1'b1, power_good_strobe_n = 1'b1;
  logic        power_down_n = 1'b1, pciStopN = 1'b1, cpuStopN = 1'b1;
  logic [7:0]  controlByte;
  strap_t      strapIn = '0;
  strap_t      strapLatched;
  smbus_in_t   busIn;
  clock_ctrl_t clockCtrl;
  int          miscompares = 0;
  int          comparisons = 0;

  // Pull-up on the data line
  assign busIn = {scl, ~(sdaLow | sdaOe)};

  smbus_host_model i_host (.clock, .sdaIn(busIn.sda), .scl, .sdaLow);

  clock_synth_smbus_config i_dut (.clock, .rst, .busIn, .sdaOut, .sdaOe, .strapIn, .power_good_strobe_n,
    .power_down_n, .pciStopN, .cpuStopN, .controlByte, .strapLatched, .strapsTaken, .transferValid, .clockCtrl);

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] want, input logic [31:0] seen);
    comparisons++;
    if (seen !== want) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, want, seen);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Straps only count once per reset, so every strap case restarts here
  task automatic power_up(input strap_t s);
    @(posedge clock);
    rst <= 1'b1;
    power_good_strobe_n <= 1'b1;
    strapIn <= s;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    power_good_strobe_n <= 1'b0;
    repeat (8) @(posedge clock);
    check("strapLatched", s, strapLatched);
  endtask

  task automatic frame(input logic [39:0] b5, input int n, input int wantAcks);
    int   acks = 0;
    logic ok;
    i_host.start_cond();
    for (int i = 0; i < n; i++) begin
      i_host.send_byte(b5[39 - 8 * i -: 8], ok);
      acks += ok;
    end
    i_host.stop_cond();
    check("ackCount", wantAcks, acks);
  endtask

  task automatic t_defaults();
    power_up(5'h15);
    check("controlByte", 8'h16, controlByte);
    check("mode", OUT_BUFFERED, clockCtrl.mode);
    check("cpuFreq", CPU_200, clockCtrl.cpuFreq);
    strapIn <= 5'h02;
    power_good_strobe_n <= 1'b1;
    repeat (8) @(posedge clock);
    check("strapHold", 5'h15, strapLatched);
  endtask

  task automatic t_write();
    frame({SLAVE_ADDR_BYTE, COMMAND_CODE, 8'h01, 8'ha8, 8'h00}, 4, 4);
    check("transferValid", 1'b1, transferValid);
    check("controlByte", 8'hbe, controlByte);
    check("spreadOn", 1'b1, clockCtrl.spreadOn);
    check("select48", 1'b1, clockCtrl.sharedSelect48);
    check("pciGatedOn", 1'b0, clockCtrl.pciGatedOn);
    check("pciFreeOn", 1'b1, clockCtrl.pciFreeOn);
    frame({SLAVE_ADDR_BYTE, COMMAND_CODE, 8'h02, 8'h00, 8'hff}, 5, 5);
    check("controlByte", 8'h16, controlByte);
    frame({SLAVE_ADDR_BYTE, COMMAND_CODE, 8'h01, 8'h00, 8'hff}, 5, 4);
  endtask

  task automatic t_refuse();
    frame({8'hd3, COMMAND_CODE, 8'h01, 8'ha8, 8'h00}, 4, 0);
    frame({8'hd0, COMMAND_CODE, 8'h01, 8'ha8, 8'h00}, 4, 0);
    frame({SLAVE_ADDR_BYTE, 8'h01, 8'h01, 8'ha8, 8'h00}, 4, 1);
    frame({SLAVE_ADDR_BYTE, COMMAND_CODE, 8'h00, 8'ha8, 8'h00}, 4, 2);
    frame({SLAVE_ADDR_BYTE, COMMAND_CODE, 8'h21, 8'ha8, 8'h00}, 4, 2);
    check("controlByte", 8'h16, controlByte);
    check("transferValid", 1'b0, transferValid);
    frame({SLAVE_ADDR_BYTE, COMMAND_CODE, COUNT_MAX, 8'h80, 8'h00}, 5, 5);
    check("controlByte", 8'h96, controlByte);
  endtask

  task automatic t_power();
    cpuStopN <= 1'b0;
    repeat (8) @(posedge clock);
    check("cpuStopBit", 1'b0, controlByte[CPU_STOP_BIT]);
    check("cpuCompOn", 1'b0, clockCtrl.cpuCompOn);
    pciStopN <= 1'b0;
    repeat (8) @(posedge clock);
    check("pciGatedOn", 1'b0, clockCtrl.pciGatedOn);
    check("cpuCompFloat", 1'b1, clockCtrl.cpuCompFloat);
    power_down_n <= 1'b0;
    repeat (8) @(posedge clock);
    check("oscRun", 1'b0, clockCtrl.oscRun);
    check("usbDotOn", 1'b0, clockCtrl.usbDotOn);
    check("pdEnables", 4'h0, {clockCtrl.cpuOn, clockCtrl.sixtySixOn, clockCtrl.bufferedOn, clockCtrl.refOn});
    power_down_n <= 1'b1;
    pciStopN <= 1'b1;
    cpuStopN <= 1'b1;
    repeat (8) @(posedge clock);
    check("enablesBack", 6'h3f, {clockCtrl.oscRun, clockCtrl.pciGatedOn, clockCtrl.cpuCompOn, clockCtrl.cpuOn,
      clockCtrl.sixtySixOn, clockCtrl.bufferedOn});
  endtask

  // Straps {mode, hi, lo, mult}: low 01, mid 00, mid 01, mid 10
  task automatic t_modes();
    logic [4:0] codes[4] = '{5'h02, 5'h08, 5'h0a, 5'h0c};
    out_mode_t  want[4] = '{OUT_INTERNAL, OUT_HIZ, OUT_TEST, OUT_RESERVED};
    for (int i = 0; i < 4; i++) begin
      power_up(codes[i]);
      check("mode", want[i], clockCtrl.mode);
      check("outputsHiZ", i == 1, clockCtrl.outputsHiZ);
      check("testClock", i == 2, clockCtrl.testClockSource);
      if (i == 0) begin
        check("cpuFreq", CPU_100, clockCtrl.cpuFreq);
      end
      if (i == 2) begin
        check("testDivs", {TEST_CPU_DIV, TEST_66_DIV, TEST_PCI_DIV, TEST_REF_DIV, TEST_48_DIV},
          {clockCtrl.cpuDiv, clockCtrl.sixtySixDiv, clockCtrl.pciDiv, clockCtrl.refDiv, clockCtrl.dot48Div});
      end
    end
  endtask

  initial begin
    t_defaults();
    t_write();
    t_refuse();
    t_power();
    t_modes();
    wrap_up();
  end
endmodule
